// ### hdl/rps_sequencer.v
// Purpose: Rhythm pattern sequencer top with AHB-Lite registers
// Assumes: Pins arrive asynchronously; one 200 MHz clock
// Notes:   Options are software registers standing in for mask choices
//
// How it works
// - Counter cycles 16 elementary times, restarting to state 1 after the last.
// - Triple-time option restarts after the twelfth state, a 12-state cycle.
// - All instrument outputs inactive while no rhythm select is asserted.
// - Down-beat active in counter state 1 for one elementary time.
// - Option picks down-beat every 8 (6) or every 16 (12) times.
// - Short rhythms are stored twice in memory to fill the cycle.
// - External reset forces state 1 and halts tempo and strobe generation.
// - Down-beat stays active throughout external reset.
// - On reset release, state-1 pattern appears immediately.
// - Trigger output pulses for 1/32 of an elementary time.
// - Continuous output active whole elementary time, staying on across set times.
// - Positive outputs idle low, go high; negative idle high, go low.
// - Each output individually set for mode and polarity; drive is one choice for all outputs.
// - At most one output continuous, others trigger.
// - Open-drain choice makes all outputs open drain.
// - Push-pull choice: triggers push-pull, the continuous one open drain.
// - Tempo clocks counter and strobe continuously unless externally reset.
// - Pattern memory is 16 rows by 30 columns, six groups of five.
`timescale 1ns/1ps
`default_nettype none
`include "rps_defines.vh"

module rps_sequencer (
   // Clock and reset
   input  wire        core_clk,
   input  wire        rstn,
   // AHB-Lite slave
   input  wire        hsel,
   input  wire [11:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   // Pins
   input  wire [5:0]  rhythm_sel,
   input  wire        ext_reset_n,
   output reg  [4:0]  inst_out,
   output reg  [4:0]  inst_oe,
   output reg         down_beat
);

   // ----------------------------------------------------------------
   // Reset release and pin synchronisers
   // ----------------------------------------------------------------
   reg       rst_m_q;
   reg       rst_n;
   reg [5:0] sel_m_q;
   reg [5:0] sel_q;
   reg       xr_m_q;
   reg       xr_n_q;

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rst_m_q <= 1'b0;
         rst_n   <= 1'b0;
      end else begin
         rst_m_q <= 1'b1;
         rst_n   <= rst_m_q;
      end
   end

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_m_q <= 6'h00;
         sel_q   <= 6'h00;
         xr_m_q  <= 1'b0;
         xr_n_q  <= 1'b0;
      end else begin
         sel_m_q <= rhythm_sel;
         sel_q   <= sel_m_q;
         xr_m_q  <= ext_reset_n;
         xr_n_q  <= xr_m_q;
      end
   end

   wire ext_rst = ~xr_n_q;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   reg [2:0]  ctrl_q;
   reg [23:0] tempo_q;
   reg [4:0]  cont_q;
   reg [4:0]  pol_q;
   reg [3:0]  pat_addr_q;
   reg        ap_wr_q;
   reg [11:0] ap_addr_q;
   wire       mem_wr;

   // One-hot continuous choice, lowest set bit wins
   wire [4:0] cont_one = cont_q & (~cont_q + 5'h01);
   wire       drv_pp   = ctrl_q[`RPS_CTRL_DRV_PP];
   wire       triple   = ctrl_q[`RPS_CTRL_TRIPLE];
   wire       short_db = ctrl_q[`RPS_CTRL_SHORTDB];

   wire take = hsel & hready & htrans[1];

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ap_wr_q   <= 1'b0;
         ap_addr_q <= 12'h000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         ap_wr_q   <= take & hwrite;
         ap_addr_q <= haddr;
      end
   end

   assign mem_wr = ap_wr_q & (ap_addr_q == `RPS_OFF_PAT_DATA);

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q     <= `RPS_CTRL_RST;
         tempo_q    <= `RPS_TEMPO_RST;
         cont_q     <= `RPS_CONT_RST;
         pol_q      <= `RPS_POL_RST;
         pat_addr_q <= 4'h0;
      end else if (ap_wr_q) begin
         case (ap_addr_q)
            `RPS_OFF_CTRL:     ctrl_q     <= hwdata[2:0];
            `RPS_OFF_TEMPO:    tempo_q    <= hwdata[23:0];
            `RPS_OFF_OUTCFG: begin
               cont_q <= hwdata[`RPS_CFG_CONT_LSB+4:`RPS_CFG_CONT_LSB];
               pol_q  <= hwdata[`RPS_CFG_POL_LSB+4:`RPS_CFG_POL_LSB];
            end
            `RPS_OFF_PAT_ADDR: pat_addr_q <= hwdata[3:0];
            default:           ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Tempo and counter
   // ----------------------------------------------------------------
   wire       sub_tick;
   reg  [4:0] sub_q;
   reg  [3:0] state_q;   // State 1 is code 0

   rps_tempo_div u_div (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .halt     (ext_rst),
      .period   (tempo_q),
      .tick_q   (sub_tick)
   );

   wire [4:0] last_state = triple ? (`RPS_STATES_TRIPLE - 5'h01)
                                  : (`RPS_STATES_FULL - 5'h01);
   wire       beat_end   = sub_tick & (sub_q == 5'h1f);

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sub_q   <= 5'h00;
         state_q <= 4'h0;
      end else if (ext_rst) begin
         sub_q   <= 5'h00;
         state_q <= 4'h0;
      end else if (sub_tick) begin
         sub_q <= sub_q + 5'h01;
         if (beat_end) begin
            if ({1'b0, state_q} == last_state)
               state_q <= 4'h0;
            else
               state_q <= state_q + 4'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Pattern memory and output shaping
   // ----------------------------------------------------------------
   wire [29:0] row_q;

   // Short rhythms live twice in the rows, nothing special here
   rps_pattern_mem u_mem (
      .core_clk  (core_clk),
      .wr_en     (mem_wr),
      .wr_row    (pat_addr_q),
      .wr_data   (hwdata[29:0]),
      .rd_row    (state_q),
      .rd_data_q (row_q)
   );

   reg [4:0] hit;
   integer   g;
   always @* begin
      hit = 5'h00;
      for (g = 0; g < `RPS_GROUPS; g = g + 1) begin
         if (sel_q[g])
            hit = hit | row_q[g*5 +: 5];
      end
   end

   // Memory read lags state by one cycle; sub_q also lags, so first
   // sub-step of each time begins a trigger
   reg       first_sub_q;
   reg [3:0] state_d1_q;
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         first_sub_q <= 1'b0;
         state_d1_q  <= 4'h0;
      end else begin
         first_sub_q <= (sub_q == 5'h00);
         state_d1_q  <= state_q;
      end
   end

   wire any_sel = |sel_q;
   wire db_hit  = (state_d1_q == 4'h0) |
                  (short_db & (state_d1_q == (triple ? 4'h6 : 4'h8)));

   genvar i;
   generate
      for (i = 0; i < `RPS_OUTS; i = i + 1) begin : g_out
         wire is_cont = cont_one[i];
         // Trigger during sub-step 0 only; continuous for whole time
         wire act = any_sel & hit[i] & (is_cont | first_sub_q);
         wire lvl = pol_q[i] ? act : ~act;
         wire od  = ~drv_pp | is_cont;
         always @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               inst_out[i] <= 1'b0;
               inst_oe[i]  <= 1'b0;
            end else begin
               inst_out[i] <= lvl;
               // Open drain drives only its low level
               inst_oe[i]  <= od ? ~lvl : 1'b1;
            end
         end
      end
   endgenerate

   // Outputs follow state 1 at once after reset since state holds 0
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         down_beat <= 1'b0;
      else
         down_beat <= db_hit | ext_rst;
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         hrdata <= 32'h00000000;
      end else if (take & ~hwrite) begin
         case (haddr)
            `RPS_OFF_CTRL:     hrdata <= {29'h0, ctrl_q};
            `RPS_OFF_TEMPO:    hrdata <= {8'h00, tempo_q};
            `RPS_OFF_STATUS:   hrdata <= {16'h0, sel_q, ext_rst, sub_q, state_q};
            `RPS_OFF_OUTCFG:   hrdata <= {19'h0, pol_q, 3'h0, cont_q};
            `RPS_OFF_PAT_ADDR: hrdata <= {28'h0, pat_addr_q};
            `RPS_OFF_PAT_DATA: hrdata <= {2'h0, row_q};
            default:           hrdata <= 32'h00000000;
         endcase
      end
   end

endmodule // rps_sequencer
`default_nettype wire

// ### hdl/rps_defines.vh
// Purpose: Constants for the rhythm pattern sequencer
// Assumes: core_clk at 200 MHz
// Notes:   Offsets are byte addresses on the AHB-Lite register bus
`ifndef RPS_DEFINES_VH
`define RPS_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RPS_OFF_CTRL      12'h000
`define RPS_OFF_TEMPO     12'h004
`define RPS_OFF_STATUS    12'h008
`define RPS_OFF_OUTCFG    12'h00c
`define RPS_OFF_PAT_ADDR  12'h010
`define RPS_OFF_PAT_DATA  12'h014

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RPS_CTRL_TRIPLE   0
`define RPS_CTRL_SHORTDB  1
`define RPS_CTRL_DRV_PP   2
`define RPS_CFG_CONT_LSB  0
`define RPS_CFG_POL_LSB   8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RPS_CTRL_RST      3'h0
`define RPS_TEMPO_RST     24'h0f4240
`define RPS_CONT_RST      5'h04
`define RPS_POL_RST       5'h1f

// ----------------------------------------------------------------
// Sequencing
// ----------------------------------------------------------------
`define RPS_STATES_FULL   5'h10
`define RPS_STATES_TRIPLE 5'h0c
`define RPS_SUBSTEPS      6'h20
`define RPS_ROWS          16
`define RPS_COLS          30
`define RPS_GROUPS        6
`define RPS_OUTS          5

`endif

// ### hdl/rps_pattern_mem.v
// Purpose: Pattern memory, 16 rows by 30 columns, registered read
// Assumes: One write port from the register file, one read port
// Notes:   Contents stand in for the mask programming
`timescale 1ns/1ps
`default_nettype none
`include "rps_defines.vh"

module rps_pattern_mem (
   // Clock
   input  wire        core_clk,
   // Write port
   input  wire        wr_en,
   input  wire [3:0]  wr_row,
   input  wire [29:0] wr_data,
   // Read port
   input  wire [3:0]  rd_row,
   output reg  [29:0] rd_data_q
);

   reg [29:0] mem [0:`RPS_ROWS-1];

   // No reset on the array: contents load from software
   always @(posedge core_clk) begin
      if (wr_en) begin
         mem[wr_row] <= wr_data;
      end
      rd_data_q <= mem[rd_row];
   end

endmodule // rps_pattern_mem
`default_nettype wire

// ### hdl/rps_tempo_div.v
// Purpose: Tempo divider giving one tick per sub-step
// Assumes: Period word from software, zero treated as one
// Notes:   Held still while halted
`timescale 1ns/1ps
`default_nettype none

module rps_tempo_div (
   // Clock and reset
   input  wire        core_clk,
   input  wire        rst_n,
   // Control
   input  wire        halt,
   input  wire [23:0] period,
   // Tick
   output reg         tick_q
);

   reg [23:0] cnt_q;

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q  <= 24'h000000;
         tick_q <= 1'b0;
      end else if (halt) begin
         cnt_q  <= 24'h000000;
         tick_q <= 1'b0;
      end else if (cnt_q + 24'h000001 >= period) begin
         cnt_q  <= 24'h000000;
         tick_q <= 1'b1;
      end else begin
         cnt_q  <= cnt_q + 24'h000001;
         tick_q <= 1'b0;
      end
   end

endmodule // rps_tempo_div
`default_nettype wire

// ### verif/rps_sequencer_sva.sv
// Purpose: Port-level checker for rps_sequencer
// Assumes: Only top-level ports visible; pins pass 2-FF syncs
// Notes:   Windows are sized to cover sync plus output register lag
`timescale 1ns/1ps
`default_nettype none
module rps_sequencer_sva (
   // Clock and reset
   input wire logic       core_clk,
   input wire logic       rstn,
   // Bus
   input wire logic [1:0] htrans,
   input wire logic       hreadyout,
   input wire logic       hresp,
   // Pins
   input wire logic [5:0] rhythm_sel,
   input wire logic       ext_reset_n,
   input wire logic [4:0] inst_out,
   input wire logic [4:0] inst_oe,
   input wire logic       down_beat
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   property p_db_hold;
      !ext_reset_n [*8] |-> down_beat;
   endproperty
   a_db_hold: assert property (p_db_hold) else $error("down beat low in external reset");
   property p_db_release;
      $rose(ext_reset_n) && down_beat |-> down_beat [*8];
   endproperty
   a_db_release: assert property (p_db_release) else $error("state one lost at release");
   property p_db_width;
      $rose(down_beat) |-> down_beat [*8] ##24 down_beat;
   endproperty
   a_db_width: assert property (p_db_width) else $error("down beat shorter than a step");
   // Register writes can move idle levels, so bus must be quiet too
   property p_quiet;
      (rhythm_sel == 6'h0 && htrans == 2'h0) [*8] |-> $stable(inst_out) && $stable(inst_oe);
   endproperty
   a_quiet: assert property (p_quiet) else $error("output moved with no rhythm");
   property p_frozen;
      (!ext_reset_n && $stable(rhythm_sel) && htrans == 2'h0) [*8] |-> $stable(inst_out);
   endproperty
   a_frozen: assert property (p_frozen) else $error("outputs moved while halted");
   property p_od;
      $past(rstn, 5) |-> (~inst_oe & ~inst_out) == 5'h0;
   endproperty
   a_od: assert property (p_od) else $error("released pin not high");
   property p_ready;
      $past(rstn) |-> hreadyout;
   endproperty
   a_ready: assert property (p_ready) else $error("wait state inserted");
   property p_okay;
      hresp == 1'b0;
   endproperty
   a_okay: assert property (p_okay) else $error("error response");

   c_ext: cover property (!ext_reset_n [*8]);
   c_beat: cover property ($rose(down_beat));
   c_play: cover property (rhythm_sel != 6'h0 && $changed(inst_out));
endmodule // rps_sequencer_sva

bind rps_sequencer rps_sequencer_sva u_sva (.core_clk(core_clk), .rstn(rstn), .htrans(htrans),
   .hreadyout(hreadyout), .hresp(hresp), .rhythm_sel(rhythm_sel), .ext_reset_n(ext_reset_n),
   .inst_out(inst_out), .inst_oe(inst_oe), .down_beat(down_beat));
`default_nettype wire

// ### verif/rps_partner.sv
// Purpose: Rhythm switches, reset key and instrument pin loads
// Assumes: External pull-up on every instrument pin
// Notes:   Switch and key levels come from the bench
`timescale 1ns/1ps
`default_nettype none
module rps_partner (
   // Bench controls
   input  wire logic [5:0] sw_closed,
   input  wire logic       reset_req,
   // Pins
   output logic      [5:0] rhythm_sel,
   output logic            ext_reset_n,
   input  wire logic [4:0] inst_out,
   input  wire logic [4:0] inst_oe,
   output logic      [4:0] inst_pin
);
   // Open switch reads low through the pull-down
   assign rhythm_sel  = sw_closed;
   assign ext_reset_n = ~reset_req;
   // Released pin floats up to the pull-up
   assign inst_pin    = (inst_out & inst_oe) | ~inst_oe;
endmodule // rps_partner
`default_nettype wire

// ### verif/testbench.sv
// Purpose: Self-checking bench for rps_sequencer
// Assumes: TEMPO of 1, so one step is 32 clocks
// Notes:   Reads and pin samples are judged from expectation queues
`timescale 1ns/1ps
`default_nettype none
`include "rps_defines.vh"
module testbench;
   logic        core_clk, rstn, hsel, hwrite, hreadyout, hresp, rd_dp, reset_req, ext_reset_n, down_beat;
   logic [11:0] haddr;
   logic [1:0]  htrans;
   logic [31:0] hwdata, hrdata, seed;
   logic [5:0]  sw_closed, rhythm_sel, sel;
   logic [4:0]  inst_out, inst_oe, inst_pin, act, ob, pol;
   logic [29:0] pat [16];
   logic [2:0]  ctrl;
   logic [31:0] exp_bus [$];
   logic [15:0] exp_pin [$];
   int          fail_count, n_compared, cyc, nst, st;

   rps_sequencer uut (.core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .rhythm_sel(rhythm_sel), .ext_reset_n(ext_reset_n), .inst_out(inst_out), .inst_oe(inst_oe),
      .down_beat(down_beat));
   rps_partner u_far (.sw_closed(sw_closed), .reset_req(reset_req), .rhythm_sel(rhythm_sel),
      .ext_reset_n(ext_reset_n), .inst_out(inst_out), .inst_oe(inst_oe), .inst_pin(inst_pin));

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Single AHB-Lite transfer; read data judged by the monitor
   task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
      @(posedge core_clk);
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'h2;
      hsel   <= 1'b1;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= w ? d : 32'h0;
      rd_dp  <= ~w;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rd_dp  <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      exp_bus.push_back(exp);
      bus(a, 1'b0, 32'h0);
   endtask

   // ----------------------------------------------------------------
   // Monitor: pre-edge values are the settled ones
   // ----------------------------------------------------------------
   always @(posedge core_clk) begin
      if (rd_dp && hreadyout)
         chk(hrdata, exp_bus.pop_front());
      if (exp_pin.size() > 0)
         chk({16'h0, down_beat, inst_pin, inst_oe, inst_out}, {16'h0, exp_pin.pop_front()});
   end

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         give_verdict();
      end
   end

   initial begin
      seed = 32'h90a4;
      rstn = 1'b0;
      hsel = 1'b0;
      haddr = 12'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      rd_dp = 1'b0;
      sw_closed = 6'h0;
      reset_req = 1'b0;
      pol = 5'b01101;
      repeat (20) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge core_clk);
      rd(`RPS_OFF_CTRL, 32'h0);
      rd(`RPS_OFF_TEMPO, 32'h0f4240);
      rd(`RPS_OFF_OUTCFG, 32'h1f04);
      rd(12'h020, 32'h0);
      bus(`RPS_OFF_TEMPO, 1'b1, 32'h1);
      bus(`RPS_OFF_OUTCFG, 1'b1, {19'h0, pol, 8'h04});
      for (int r = 0; r < 16; r++) begin
         void'(xs());
         pat[r] = seed[29:0];
         if (r > 7)
            pat[r][4:0] = pat[r-8][4:0];
         bus(`RPS_OFF_PAT_ADDR, 1'b1, 32'(r));
         bus(`RPS_OFF_PAT_DATA, 1'b1, {2'h0, pat[r]});
      end
      // Modes: idle, triple push-pull, short beat, triple short push-pull
      for (int m = 0; m < 4; m++) begin
         // Pin changes belong on the rising edge, not the sampling negedge
         @(posedge core_clk);
         ctrl = {m[0], m[1], m[0]};
         void'(xs());
         sel = (m == 0) ? 6'h0 : (seed[5:0] | 6'h01);
         sw_closed <= sel;
         bus(`RPS_OFF_CTRL, 1'b1, {29'h0, ctrl});
         reset_req <= 1'b1;
         repeat (20) @(posedge core_clk);
         rd(`RPS_OFF_STATUS, {16'h0, sel, 10'h200});
         reset_req <= 1'b0;
         nst = ctrl[0] ? 12 : 16;
         // First low down beat marks the start of state two
         do @(negedge core_clk); while (down_beat !== 1'b0);
         for (int k = 32; k <= nst * 32 + 32; k++) begin
            st = (k / 32) % nst;
            act = 5'h0;
            for (int g = 0; g < 6; g++)
               if (sel[g])
                  act |= pat[st][g*5 +: 5];
            if (k % 32 != 0)
               act &= 5'b00100;
            ob = act ^ ~pol;
            exp_pin.push_back({st == 0 || (ctrl[1] && st == nst / 2), ob, ctrl[2] ? (5'b11011 | ~ob) : ~ob, ob});
            @(negedge core_clk);
         end
      end
      repeat (2) @(posedge core_clk);
      give_verdict();
   end
endmodule // testbench
`default_nettype wire
